// [rtl/ebc_pkg.sv]
// Constants shared by the elastic store address-compare checker
package ebc_pkg;
  localparam int EBC_ADDR_W = 4;
  localparam int EBC_DEPTH = 16;
  localparam logic [3:0] EBC_WR_ADDR_RST = 4'h8;
  localparam logic [3:0] EBC_RD_ADDR_RST = 4'h0;
  localparam logic [3:0] EBC_ADDR_LAG = 4'h8;
  localparam logic [3:0] EBC_ADDR_STEP = 4'h1;
  localparam logic [15:0] EBC_STORE_RST = 16'h0000;
  localparam int EBC_N_IN = 8;
  localparam int EBC_IN_STROBE = 0;
  localparam int EBC_IN_WCLK = 1;
  localparam int EBC_IN_RCLK = 2;
  localparam int EBC_IN_WDATA = 3;
  localparam int EBC_IN_DFAULT_N = 4;
  localparam int EBC_IN_TFAULT = 5;
  localparam int EBC_IN_CLEAR = 6;
  localparam int EBC_IN_INHIBIT = 7;
  localparam logic [7:0] EBC_SYNC_RST = 8'h10;
endpackage

// [rtl/ebc_sync.sv]
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
module ebc_sync #(
  parameter int N = 8,
  parameter logic [N-1:0] RST = '0
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [N-1:0] din,
  output logic [N-1:0] level,
  output logic [N-1:0] rise
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
  } ebc_sync_s;

  ebc_sync_s s;
  ebc_sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // A change counts only once stages two and three agree
    next_s.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 | s.s3));
    next_s.rise = next_s.lvl & ~s.lvl;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s.s1 <= RST;
      s.s2 <= RST;
      s.s3 <= RST;
      s.lvl <= RST;
      s.rise <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;
  assign rise = s.rise;
endmodule // ebc_sync

// [rtl/ebc_check.sv]
// Elastic store with online address-compare self check and card error logic
`timescale 1ns/100ps
module ebc_check
  import ebc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic FRAME_WORD24_BIT0_STROBE,
  input wire logic WRITE_CLK,
  input wire logic WRITE_DATA,
  input wire logic READ_CLK,
  input wire logic DATA_DRIVER_FAULT_N,
  input wire logic TIMING_DRIVER_FAULT,
  input wire logic FRONT_PANEL_ERROR_CLEAR,
  input wire logic ERROR_STROBE_INHIBIT,
  output logic READ_DATA,
  output logic CHECK_BUSY,
  output logic COMPARE_ERROR,
  output logic DRIVER_ERROR,
  output logic CARD_ERROR_OUT,
  output logic CARD_ERROR_OUT_N
);
  typedef struct packed {
    logic [15:0] store;
    logic [3:0] wr_addr;
    logic [3:0] rd_addr;
    logic rd_data;
    logic [3:0] latched;
    logic ref_bit;
    logic pending;
    logic cmp_on;
    logic busy;
    logic cmp_en;
    logic cmp_err;
    logic drv_err;
    logic card_err;
  } ebc_state_s;

  ebc_state_s s;
  ebc_state_s next_s;
  logic [EBC_N_IN-1:0] pin_in;
  logic [EBC_N_IN-1:0] lvl;
  logic [EBC_N_IN-1:0] rise;
  logic wr_tick;
  logic rd_tick;
  logic start;
  logic eq;
  logic drv_fault;
  logic clear;
  logic [3:0] wr_last;

  assign pin_in = {ERROR_STROBE_INHIBIT, FRONT_PANEL_ERROR_CLEAR, TIMING_DRIVER_FAULT, DATA_DRIVER_FAULT_N,
                   WRITE_DATA, READ_CLK, WRITE_CLK, FRAME_WORD24_BIT0_STROBE};

  // All inputs come from the loop or the panel, so each is filtered alike
  ebc_sync #(
    .N(EBC_N_IN),
    .RST(EBC_SYNC_RST)
  ) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .din(pin_in),
    .level(lvl),
    .rise(rise)
  );

  assign wr_tick = rise[EBC_IN_WCLK];
  assign rd_tick = rise[EBC_IN_RCLK];
  assign clear = lvl[EBC_IN_CLEAR];
  // Last location written; its bit is settled, unlike the one about to be written
  assign wr_last = s.wr_addr - EBC_ADDR_STEP;
  // No timeout: a slow channel simply keeps the check open
  assign start = rise[EBC_IN_STROBE] && !s.busy && !s.pending;
  assign eq = s.cmp_on && (s.rd_addr == s.latched);
  assign drv_fault = ~lvl[EBC_IN_DFAULT_N] | lvl[EBC_IN_TFAULT];

  always_comb begin
    next_s = s;
    if (wr_tick) begin
      next_s.store[s.wr_addr] = lvl[EBC_IN_WDATA];
      next_s.wr_addr = s.wr_addr + EBC_ADDR_STEP;
    end
    if (start) begin
      next_s.latched = wr_last;
      next_s.ref_bit = s.store[wr_last];
      next_s.pending = 1'b1;
    end
    if (rd_tick) begin
      next_s.rd_data = s.store[s.rd_addr];
      next_s.rd_addr = s.rd_addr + EBC_ADDR_STEP;
      next_s.cmp_en = eq;
      if (s.pending) begin
        next_s.cmp_on = 1'b1;
        next_s.busy = 1'b1;
        next_s.pending = 1'b0;
      end
    end
    if (clear) begin
      next_s.cmp_err = 1'b0;
      next_s.drv_err = 1'b0;
    end
    // Placed after the clear so a coincident error is kept
    if (s.cmp_en) begin
      if (s.rd_data ^ s.ref_bit) begin
        next_s.cmp_err = 1'b1;
      end
      next_s.cmp_en = 1'b0;
      next_s.cmp_on = 1'b0;
      next_s.busy = 1'b0;
    end
    if (drv_fault) begin
      next_s.drv_err = 1'b1;
    end
    next_s.card_err = !lvl[EBC_IN_INHIBIT] && (s.cmp_err || s.drv_err);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s.store <= EBC_STORE_RST;
      s.wr_addr <= EBC_WR_ADDR_RST;
      s.rd_addr <= EBC_RD_ADDR_RST;
      s.rd_data <= 1'b0;
      s.latched <= EBC_RD_ADDR_RST;
      s.ref_bit <= 1'b0;
      s.pending <= 1'b0;
      s.cmp_on <= 1'b0;
      s.busy <= 1'b0;
      s.cmp_en <= 1'b0;
      s.cmp_err <= 1'b0;
      s.drv_err <= 1'b0;
      s.card_err <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign READ_DATA = s.rd_data;
  assign CHECK_BUSY = s.busy;
  assign COMPARE_ERROR = s.cmp_err;
  assign DRIVER_ERROR = s.drv_err;
  assign CARD_ERROR_OUT = s.card_err;
  assign CARD_ERROR_OUT_N = ~s.card_err;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_pend_tick;
    s.pending && rd_tick;
  endsequence
  sequence s_mismatch;
    s.cmp_en && (s.rd_data != s.ref_bit);
  endsequence
  sequence s_err_out;
    s.cmp_err ##1 (s.card_err || $past(lvl[EBC_IN_INHIBIT]));
  endsequence

  property p_start;
    start |=> s.pending && !s.busy;
  endproperty
  a_start: assert property (p_start) else $error("strobe did not open a check");

  property p_ignore;
    rise[EBC_IN_STROBE] && (s.busy || s.pending) |=> $stable(s.latched) && $stable(s.ref_bit);
  endproperty
  a_ignore: assert property (p_ignore) else $error("strobe during check disturbed reference");

  property p_addr_cap;
    start |=> s.latched == $past(wr_last);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("latched address wrong");

  property p_bit_cap;
    start |=> s.ref_bit == $past(s.store[wr_last]);
  endproperty
  a_bit_cap: assert property (p_bit_cap) else $error("reference bit wrong");

  property p_arm;
    s_pend_tick |=> s.busy && s.cmp_on && !s.pending;
  endproperty
  a_arm: assert property (p_arm) else $error("pending not moved on read clock");

  property p_equal;
    s.cmp_on && rd_tick && (s.rd_addr == s.latched) && !s.cmp_en |=> s.cmp_en;
  endproperty
  a_equal: assert property (p_equal) else $error("address match did not enable compare");

  property p_match;
    s.cmp_en && (s.rd_data == s.ref_bit) && !s.cmp_err |=> !s.cmp_err;
  endproperty
  a_match: assert property (p_match) else $error("equal bits flagged error");

  property p_mismatch;
    s_mismatch |=> s_err_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch did not raise card error");

  property p_lag;
    wr_tick == rd_tick |=> (s.wr_addr - s.rd_addr) == $past(s.wr_addr - s.rd_addr);
  endproperty
  a_lag: assert property (p_lag) else $error("address spacing drifted");

  property p_drv;
    drv_fault |=> s.drv_err;
  endproperty
  a_drv: assert property (p_drv) else $error("driver fault not latched");

  property p_hold;
    s.drv_err && !clear |=> s.drv_err;
  endproperty
  a_hold: assert property (p_hold) else $error("driver error dropped without clear");

  property p_card;
    (s.cmp_err || s.drv_err) && !lvl[EBC_IN_INHIBIT] |=> CARD_ERROR_OUT && !CARD_ERROR_OUT_N;
  endproperty
  a_card: assert property (p_card) else $error("card error not asserted");

  property p_done;
    s.cmp_en |=> !s.cmp_en && !s.busy && !s.cmp_on;
  endproperty
  a_done: assert property (p_done) else $error("check did not close after compare");
endmodule // ebc_check

// [bench/ebc_far.sv]
// Far-side model: write clock, gated read clock and write data pattern
`timescale 1ns/100ps
module ebc_far (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold_rd,
  input wire logic inv,
  output logic wr_clk,
  output logic wr_data,
  output logic rd_clk,
  output logic [7:0] ticks,
  output logic [3:0] phase
);
  // Five cycles per level so the pin filter sees every edge
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 4'h0;
      ticks <= 8'h00;
      wr_clk <= 1'h0;
      rd_clk <= 1'h0;
      wr_data <= 1'h0;
    end else begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
      // Clocks run on while hold_rd is low, so a check completes in about eight ticks
      if (phase == 4'h9) begin
        ticks <= ticks + 8'h01;
        wr_clk <= 1'h1;
        rd_clk <= !hold_rd;
      end else if (phase > 4'h3) begin
        wr_clk <= 1'h0;
        rd_clk <= 1'h0;
      end
      // Data settles three cycles before the write edge
      if (phase == 4'h6) begin
        wr_data <= ticks[0] ^ ticks[3] ^ inv;
      end
    end
  end
endmodule // ebc_far

// [bench/tb_top.sv]
// Self-checking bench for the elastic store address-compare checker
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic stb = 1'h0;
  logic dfault_n = 1'h1;
  logic tfault = 1'h0;
  logic clr = 1'h0;
  logic inh = 1'h0;
  logic hold = 1'h0;
  logic inv = 1'h0;
  logic wclk, wdata, rclk, rdata, busy, cerr, derr, cout, cout_n;
  logic [7:0] ticks;
  logic [3:0] phase;
  int num_errors = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  ebc_check i_ebc_check (.CLK(clk), .RESET(reset), .FRAME_WORD24_BIT0_STROBE(stb), .WRITE_CLK(wclk),
    .WRITE_DATA(wdata), .READ_CLK(rclk), .DATA_DRIVER_FAULT_N(dfault_n), .TIMING_DRIVER_FAULT(tfault),
    .FRONT_PANEL_ERROR_CLEAR(clr), .ERROR_STROBE_INHIBIT(inh), .READ_DATA(rdata), .CHECK_BUSY(busy),
    .COMPARE_ERROR(cerr), .DRIVER_ERROR(derr), .CARD_ERROR_OUT(cout), .CARD_ERROR_OUT_N(cout_n));
  ebc_far i_ebc_far (.clk(clk), .reset(reset), .hold_rd(hold), .inv(inv), .wr_clk(wclk), .wr_data(wdata),
    .rd_clk(rclk), .ticks(ticks), .phase(phase));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded waits: a hang counts as a mismatch and ends the run
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (busy !== v) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic wait_tp(input logic [7:0] tk);
    int k;
    k = 0;
    while ((ticks !== tk || phase !== 4'h8) && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (ticks !== tk || phase !== 4'h8) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic strobe_pulse();
    @(posedge clk);
    stb <= 1'h1;
    repeat (5) @(posedge clk);
    stb <= 1'h0;
  endtask

  task automatic clear_pulse();
    clr <= 1'h1;
    repeat (8) @(posedge clk);
    clr <= 1'h0;
    repeat (12) @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    `CHK("card_error_n", 1'h1, cout_n)
    // Read stream must show the bit written eight locations earlier
    for (int t = 8; t < 24; t++) begin
      wait_tp(8'(t + 1));
      `CHK("read_data", t[0] ^ ~t[3], rdata)
    end
    strobe_pulse();
    wait_busy(1'h1);
    strobe_pulse();
    wait_busy(1'h0);
    // Start at tick 25 latches location 15; a restart on the ignored strobe would end at tick 34
    `CHK("done_tick", 8'h20, ticks)
    `CHK("compare_error", 1'h0, cerr)
    repeat (200) @(posedge clk);
    `CHK("busy", 1'h0, busy)
    // Stall reads for 32 writes so the reference location is rewritten inverted
    strobe_pulse();
    wait_busy(1'h1);
    hold <= 1'h1;
    inv <= 1'h1;
    repeat (320) @(posedge clk);
    hold <= 1'h0;
    wait_busy(1'h0);
    repeat (3) @(posedge clk);
    `CHK("compare_error", 1'h1, cerr)
    `CHK("card_error", 1'h1, cout)
    `CHK("card_error_n", 1'h0, cout_n)
    inh <= 1'h1;
    repeat (8) @(posedge clk);
    `CHK("card_error", 1'h0, cout)
    inh <= 1'h0;
    clear_pulse();
    `CHK("compare_error", 1'h0, cerr)
    for (int i = 0; i < 2; i++) begin
      dfault_n <= (i != 0);
      tfault <= (i == 1);
      repeat (10) @(posedge clk);
      dfault_n <= 1'h1;
      tfault <= 1'h0;
      repeat (12) @(posedge clk);
      `CHK("driver_error", 1'h1, derr)
      `CHK("card_error", 1'h1, cout)
      clear_pulse();
      `CHK("card_error", 1'h0, cout)
    end
    print_verdict();
  end
endmodule // tb_top
